// ==== spr_defs.vh ====
// Offsets, fields, reset values and frame constants of the serial line router
`ifndef SPR_DEFS_VH
`define SPR_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SPR_A_CFG      8'h00
`define SPR_A_PINSEL   8'h04
`define SPR_A_MASK     8'h08
`define SPR_A_ROUTE    8'h0c
`define SPR_A_STATUS   8'h10

// ****************************************
// Reset values and writable bits
// ****************************************
`define SPR_CFG_RST    32'h00000000
`define SPR_CFG_WM     32'h00000337
`define SPR_PSEL_RST   32'h00000000
`define SPR_PSEL_WM    32'h00007f7f
`define SPR_MASK_RST   32'h0000ffff
`define SPR_MASK_WM    32'h0000ffff
`define SPR_ROUTE_RST  32'h0000003f
`define SPR_ROUTE_WM   32'h0000003f

// ****************************************
// Field positions
// ****************************************
`define SPR_CFG_MUX    0
`define SPR_CFG_BUS    4
`define SPR_CFG_ECHO   8
`define SPR_CFG_LOOP   9
`define SPR_RT_D       0
`define SPR_RT_B1      2
`define SPR_RT_B2      4

// ****************************************
// Bus types, channel codes, frame
// ****************************************
`define SPR_BUS_PCM    2'h0
`define SPR_BUS_LINK   2'h1
`define SPR_BUS_CIRC   2'h2
`define SPR_CH_B1      3'h0
`define SPR_CH_B2      3'h1
`define SPR_CH_D       3'h2
`define SPR_CH_A       3'h3
`define SPR_CH_M       3'h4
`define SPR_RT_NONE    2'h3
`define SPR_FRAME_LAST 5'h13
`define SPR_FRAME_US   125
`define SPR_RESP_OK    2'h0
`define SPR_RESP_ERR   2'h2

`endif

// ==== spr_router.v ====
// Serial line router: controller pin mux, shared time-slot bus and register slave
`timescale 1ns/1ps
`default_nettype none
`include "spr_defs.vh"

module spr_router (
	input  wire        clk,
	input  wire        rstn,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	input  wire [2:0]  scc_txd,
	input  wire [2:0]  scc_rts,
	input  wire [2:0]  scc_brg,
	input  wire [2:0]  scc_dreq,
	output wire [2:0]  scc_rxd,
	output wire [2:0]  scc_rclk,
	output wire [2:0]  scc_tclk,
	output wire [2:0]  scc_cts,
	output wire [2:0]  scc_cd,
	output reg  [2:0]  scc_dcoll,
	input  wire [1:0]  mgmt_txd,
	output reg  [1:0]  mgmt_rxd,
	output reg  [1:0]  mgmt_rstb,
	output reg  [1:0]  mgmt_tstb,
	input  wire [20:0] pin_i,
	output reg  [20:0] pin_o,
	output reg  [20:0] pin_oen,
	input  wire [13:0] alt_o,
	input  wire [13:0] alt_oen,
	output wire [13:0] alt_i,
	output wire [2:0]  baud_clock_out,
	output reg         first_bearer_strobe,
	output reg         second_bearer_strobe
);

	// ****************************************
	// Helpers
	// ****************************************
	function [31:0] wmerge(input [31:0] o, input [31:0] d, input [3:0] s);
		integer b;
		begin
			wmerge = o;
			for (b = 0; b < 4; b = b + 1) begin
				if (s[b])
					wmerge[8*b +: 8] = d[8*b +: 8];
			end
		end
	endfunction

	function known(input [7:0] a);
		begin
			known = (a == `SPR_A_CFG) || (a == `SPR_A_PINSEL) || (a == `SPR_A_MASK) ||
				(a == `SPR_A_ROUTE) || (a == `SPR_A_STATUS);
		end
	endfunction

	// Slot layout of the 20-bit frame, two 10-bit halves per frame
	function [2:0] slot(input [4:0] n);
		begin
			if (n < 5'h08)
				slot = `SPR_CH_B1;
			else if (n == 5'h08 || n == 5'h12)
				slot = `SPR_CH_D;
			else if (n == 5'h09)
				slot = `SPR_CH_A;
			else if (n < 5'h12)
				slot = `SPR_CH_B2;
			else
				slot = `SPR_CH_M;
		end
	endfunction

	function men(input [4:0] n, input [15:0] m);
		reg [4:0] j;
		begin
			j = n - 5'h0a;
			if (n < 5'h08)
				men = m[n[2:0]];
			else if (n >= 5'h0a && n < 5'h12)
				men = m[{1'b1, j[2:0]}];
			else
				men = 1'b1;
		end
	endfunction

	// One-hot controller owning a channel; zero if unrouted or not on the bus
	function [2:0] hot(input [2:0] ch, input [5:0] r, input [2:0] e);
		reg [1:0] x;
		begin
			case (ch)
				`SPR_CH_B1: x = r[`SPR_RT_B1 +: 2];
				`SPR_CH_B2: x = r[`SPR_RT_B2 +: 2];
				`SPR_CH_D: x = r[`SPR_RT_D +: 2];
				default: x = `SPR_RT_NONE;
			endcase
			hot = (x == `SPR_RT_NONE) ? 3'h0 : ((3'h1 << x) & e);
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg  [31:0] cfg_reg;
	reg  [31:0] psel_reg;
	reg  [31:0] mask_reg;
	reg  [31:0] route_reg;
	reg         aw_h;
	reg         w_h;
	reg  [7:0]  aw_a;
	reg  [31:0] w_d;
	reg  [3:0]  w_s;
	wire [2:0]  mux_sel = cfg_reg[`SPR_CFG_MUX +: 3];
	wire [1:0]  bus = cfg_reg[`SPR_CFG_BUS +: 2];
	wire        echo = cfg_reg[`SPR_CFG_ECHO];
	wire        loop = cfg_reg[`SPR_CFG_LOOP];
	// Others may only join once the first is on the bus
	wire [2:0]  em = {mux_sel[2] & mux_sel[0], mux_sel[1] & mux_sel[0], mux_sel[0]};
	wire        bad = (|mux_sel[2:1]) & ~mux_sel[0];
	wire [5:0]  rt = route_reg[5:0];
	wire [15:0] mk = mask_reg[15:0];
	wire        req;
	reg  [4:0]  cnt;
	reg         act;
	reg         gnt_reg;

	assign s_axi_awready = ~aw_h;
	assign s_axi_wready = ~w_h;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= `SPR_CFG_RST;
			psel_reg <= `SPR_PSEL_RST;
			mask_reg <= `SPR_MASK_RST;
			route_reg <= `SPR_ROUTE_RST;
			aw_h <= 1'b0;
			w_h <= 1'b0;
			aw_a <= 8'h00;
			w_d <= 32'h00000000;
			w_s <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPR_RESP_OK;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SPR_RESP_OK;
		end else begin
			if (s_axi_awvalid && !aw_h) begin
				aw_h <= 1'b1;
				aw_a <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_h) begin
				w_h <= 1'b1;
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_h && w_h && !s_axi_bvalid) begin
				aw_h <= 1'b0;
				w_h <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known(aw_a) ? `SPR_RESP_OK : `SPR_RESP_ERR;
				case (aw_a)
					`SPR_A_CFG: cfg_reg <= wmerge(cfg_reg, w_d, w_s) & `SPR_CFG_WM;
					`SPR_A_PINSEL: psel_reg <= wmerge(psel_reg, w_d, w_s) & `SPR_PSEL_WM;
					`SPR_A_MASK: mask_reg <= wmerge(mask_reg, w_d, w_s) & `SPR_MASK_WM;
					`SPR_A_ROUTE: route_reg <= wmerge(route_reg, w_d, w_s) & `SPR_ROUTE_WM;
					default: ;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= known(s_axi_araddr) ? `SPR_RESP_OK : `SPR_RESP_ERR;
				case (s_axi_araddr)
					`SPR_A_CFG: s_axi_rdata <= cfg_reg;
					`SPR_A_PINSEL: s_axi_rdata <= psel_reg;
					`SPR_A_MASK: s_axi_rdata <= mask_reg;
					`SPR_A_ROUTE: s_axi_rdata <= route_reg;
					`SPR_A_STATUS: s_axi_rdata <= {23'h0, bad, req, gnt_reg, act, cnt};
					default: s_axi_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg [20:0] pa_reg;
	reg [20:0] sp;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pa_reg <= 21'h000000;
			sp <= 21'h000000;
		end else begin
			pa_reg <= pin_i;
			sp <= pa_reg;
		end
	end
	assign alt_i = sp[20:7];

	// ****************************************
	// Shared bus engine on the first pin set
	// ****************************************
	// The far end owns the bit clock; we only follow its edges
	wire       lrx = sp[2];
	wire       lclk = sp[3];
	wire       lgr = sp[5];
	wire       lsy = sp[6];
	reg        lq;
	reg        tx_bit;
	reg        tx_en;
	reg  [2:0] rx_o;
	reg  [2:0] rstb;
	reg  [2:0] tstb;
	wire       rise = em[0] & lclk & ~lq;
	wire       fall = em[0] & ~lclk & lq;
	wire [4:0] c = lsy ? 5'h00 : cnt;
	wire [2:0] ch_r = slot(c);
	wire [2:0] oh_r = hot(ch_r, rt, em);
	wire       en_r = men(c, mk);
	wire       act_n = lsy | act;
	wire       gnt_n = lsy ? lgr : gnt_reg;
	wire [2:0] ch_f = slot(cnt);
	wire [2:0] oh_f = hot(ch_f, rt, em);
	wire       rxb = loop ? (tx_en ? tx_bit : 1'b1) : lrx;
	wire       d_ok = gnt_n & lgr & req;
	wire       mg_r = (ch_r == `SPR_CH_A) | (ch_r == `SPR_CH_M);
	wire       src = (ch_r == `SPR_CH_M) ? mgmt_txd[0] :
		(ch_r == `SPR_CH_A) ? mgmt_txd[1] : |(scc_txd & oh_r);
	wire       drive = act_n & en_r &
		((ch_r == `SPR_CH_D) ? d_ok : ((|oh_r) | mg_r));

	assign req = em[0] & |(scc_dreq & hot(`SPR_CH_D, rt, em));

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lq <= 1'b0;
			cnt <= 5'h00;
			act <= 1'b0;
			gnt_reg <= 1'b0;
			tx_bit <= 1'b1;
			tx_en <= 1'b0;
			rx_o <= 3'h0;
			rstb <= 3'h0;
			tstb <= 3'h0;
			scc_dcoll <= 3'h0;
			mgmt_rxd <= 2'h0;
			mgmt_rstb <= 2'h0;
			mgmt_tstb <= 2'h0;
			first_bearer_strobe <= 1'b0;
			second_bearer_strobe <= 1'b0;
		end else begin
			lq <= lclk;
			rstb <= 3'h0;
			tstb <= 3'h0;
			scc_dcoll <= 3'h0;
			mgmt_rstb <= 2'h0;
			mgmt_tstb <= 2'h0;
			if (!em[0]) begin
				act <= 1'b0;
				tx_en <= 1'b0;
				first_bearer_strobe <= 1'b0;
				second_bearer_strobe <= 1'b0;
			end else if (rise) begin
				if (lsy) begin
					cnt <= 5'h00;
					act <= 1'b1;
					gnt_reg <= lgr;
				end
				if (ch_r == `SPR_CH_D && gnt_n && req && !lgr) begin
					gnt_reg <= 1'b0;
					scc_dcoll <= oh_r;
				end
				if (echo) begin
					tx_bit <= lrx;
					tx_en <= act_n;
				end else begin
					tx_bit <= src;
					tx_en <= drive;
					tstb <= drive ? oh_r : 3'h0;
					mgmt_tstb <= {drive & (ch_r == `SPR_CH_A), drive & (ch_r == `SPR_CH_M)};
				end
				first_bearer_strobe <= act_n & en_r & (ch_r == `SPR_CH_B1);
				second_bearer_strobe <= act_n & en_r & (ch_r == `SPR_CH_B2);
			end else if (fall && act) begin
				if (men(cnt, mk)) begin
					rx_o <= (rx_o & ~oh_f) | ({3{rxb}} & oh_f);
					rstb <= oh_f;
					if (ch_f == `SPR_CH_M) begin
						mgmt_rxd[0] <= rxb;
						mgmt_rstb[0] <= 1'b1;
					end
					if (ch_f == `SPR_CH_A) begin
						mgmt_rxd[1] <= rxb;
						mgmt_rstb[1] <= 1'b1;
					end
				end
				cnt <= cnt + 5'h01;
				if (cnt == `SPR_FRAME_LAST) begin
					act <= 1'b0;
					tx_en <= 1'b0;
					first_bearer_strobe <= 1'b0;
					second_bearer_strobe <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Pin ownership
	// ****************************************
	// Bus-side pins use the first set; open-drain style on the circuit bus
	wire       ltx_o = (bus == `SPR_BUS_CIRC) ? 1'b0 : tx_bit;
	wire       ltx_oen = (bus == `SPR_BUS_CIRC) ? ~(tx_en & ~tx_bit) : ~tx_en;
	wire [20:0] own = {psel_reg[14:8], psel_reg[6:0], 7'h7f};
	integer k;
	integer p;
	integer ix;
	always @* begin
		pin_o = 21'h000000;
		pin_oen = 21'h1fffff;
		for (k = 0; k < 3; k = k + 1) begin
			for (p = 0; p < 7; p = p + 1) begin
				ix = k * 7 + p;
				if (k == 0 && em[0]) begin
					if (p == 0) begin
						pin_o[ix] = ltx_o;
						pin_oen[ix] = ltx_oen;
					end else if (p == 1) begin
						pin_o[ix] = scc_brg[0];
						pin_oen[ix] = 1'b0;
					end else if (p == 4) begin
						pin_o[ix] = req;
						pin_oen[ix] = 1'b0;
					end
				end else if (k > 0 && (!own[ix] || (em[k] && p != 1))) begin
					pin_o[ix] = alt_o[ix - 7];
					pin_oen[ix] = alt_oen[ix - 7];
				end else if (em[k]) begin
					pin_o[ix] = scc_brg[k];
					pin_oen[ix] = 1'b0;
				end else if (p == 0) begin
					pin_o[ix] = scc_txd[k];
					pin_oen[ix] = 1'b0;
				end else if (p == 4) begin
					pin_o[ix] = scc_rts[k];
					pin_oen[ix] = 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Controller side
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : ctl
			assign scc_rxd[g] = em[g] ? rx_o[g] : sp[g*7+2];
			assign scc_rclk[g] = em[g] ? rstb[g] : sp[g*7+3];
			assign scc_tclk[g] = em[g] ? tstb[g] : sp[g*7+1];
			assign scc_cts[g] = em[g] | sp[g*7+5];
			assign scc_cd[g] = em[g] | sp[g*7+6];
			assign baud_clock_out[g] = em[g] ? 1'b0 : scc_brg[g];
		end
	endgenerate

endmodule
`default_nettype wire

// ==== spr_router_monitor.sv ====
// Concurrent checks on the router's register bus and line outputs
`timescale 1ns/1ps
`default_nettype none
module spr_router_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [2:0]  scc_brg,
	input wire logic [2:0]  baud_clock_out,
	input wire logic [1:0]  mgmt_tstb,
	input wire logic        first_bearer_strobe,
	input wire logic        second_bearer_strobe
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_AW_ONCE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address taken twice");
	AST_W_ONCE: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("data taken twice");
	AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_BAUD: assert property ((baud_clock_out & ~scc_brg) == 3'h0)
		else $error("baud clock from wrong source");
	AST_STROBE_SPLIT: assert property (!(first_bearer_strobe && second_bearer_strobe))
		else $error("both strobes high");
	AST_STROBE_HOLD: assert property ($rose(first_bearer_strobe) |=> first_bearer_strobe[*3])
		else $error("strobe shorter than a bit");
	AST_MGMT: assert property (mgmt_tstb[0] |=> (!mgmt_tstb[0])[*4])
		else $error("management pulse repeated");
endmodule
`default_nettype wire

// ==== spr_link_model.sv ====
// Link master model: bit clock, frame sync, grant and pulled-up data lines
`timescale 1ns/1ps
`default_nettype none
module spr_link_model (
	output var logic  line_bit_clock,
	output var logic  frame_sync_in,
	output var logic  dchannel_grant_in,
	output var logic  line_receive_data,
	input wire logic  line_tx_level,
	input wire logic  line_tx_float
);
	localparam int QTR = 40;
	localparam int HALF = 80;
	logic wire_level;
	// Pull-up wins whenever the device floats its transmit line
	assign wire_level = line_tx_float ? 1'b1 : line_tx_level;
	initial begin
		line_bit_clock = 1'b0;
		frame_sync_in = 1'b0;
		dchannel_grant_in = 1'b1;
		line_receive_data = 1'b1;
	end
	// Clock stands still between frames
	task automatic run_frame(input logic [19:0] pat, input logic [19:0] gpat,
		output logic [19:0] seen, output int drv);
		drv = 0;
		for (int i = 0; i < 20; i++) begin
			line_receive_data = pat[i];
			frame_sync_in = (i == 0);
			dchannel_grant_in = gpat[i];
			#QTR line_bit_clock = 1'b1;
			#HALF line_bit_clock = 1'b0;
			seen[i] = wire_level;
			drv += (line_tx_float === 1'b0);
			#QTR;
		end
		frame_sync_in = 1'b0;
		line_receive_data = 1'b1;
		dchannel_grant_in = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== spr_router_test.sv ====
// Self-checking bench for the serial line router
`timescale 1ns/1ps
`default_nettype none
`include "spr_defs.vh"
module spr_router_test;
	logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, first_bearer_strobe, second_bearer_strobe;
	logic        lclk, lsync, lgrant, lrx, rx_or;
	logic [1:0]  s_axi_bresp, s_axi_rresp, mgmt_txd, mgmt_rxd, mgmt_rstb, mgmt_tstb, r;
	logic [2:0]  scc_txd, scc_rts, scc_brg, scc_dreq, scc_rxd, scc_rclk, scc_tclk;
	logic [2:0]  scc_cts, scc_cd, scc_dcoll, baud_clock_out;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [13:0] alt_o, alt_oen, alt_i, pins_hi;
	logic [19:0] seen;
	logic [20:0] pin_i, pin_o, pin_oen;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	int          num_errors, check_count, cyc, drv, nrc, nst, ntc, nmg, ndc;
	assign pin_i = {pins_hi, lsync, lgrant, 1'b0, lclk, lrx, 2'b00};
	spr_router dut_u (.clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .scc_txd, .scc_rts, .scc_brg, .scc_dreq, .scc_rxd, .scc_rclk,
		.scc_tclk, .scc_cts, .scc_cd, .scc_dcoll, .mgmt_txd, .mgmt_rxd, .mgmt_rstb, .mgmt_tstb,
		.pin_i, .pin_o, .pin_oen, .alt_o, .alt_oen, .alt_i, .baud_clock_out,
		.first_bearer_strobe, .second_bearer_strobe);
	spr_link_model lnk_u (.line_bit_clock(lclk), .frame_sync_in(lsync),
		.dchannel_grant_in(lgrant), .line_receive_data(lrx),
		.line_tx_level(pin_o[0]), .line_tx_float(pin_oen[0]));
	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, b_d;
		b_d = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_d) begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			b_d = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, r_d;
		r_d = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_d) begin
			@(negedge clk);
			ta = s_axi_arready;
			r_d = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask
	// Runs one frame while counting receive pulses and strobe bursts
	task automatic frame(input logic [19:0] pat, input logic [19:0] gpat);
		logic prev;
		prev = 1'b0;
		nrc = 0;
		nst = 0;
		ntc = 0;
		nmg = 0;
		ndc = 0;
		rx_or = 1'b0;
		fork
			lnk_u.run_frame(pat, gpat, seen, drv);
			repeat (360) begin
				@(negedge clk);
				if (scc_rclk[0] === 1'b1) begin
					nrc++;
					rx_or = rx_or | scc_rxd[0];
				end
				if (scc_tclk[0] === 1'b1) ntc++;
				if (scc_dcoll[0] === 1'b1) ndc++;
				if (mgmt_rstb !== 2'b00) nmg++;
				if (first_bearer_strobe === 1'b1 && !prev) nst++;
				prev = (first_bearer_strobe === 1'b1);
			end
		join
	endtask
	task tally_and_finish;
		$display("TB: %0d checks, %0d errors", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task t_reset;
		rchk(`SPR_A_CFG, `SPR_CFG_RST);
		rchk(`SPR_A_PINSEL, `SPR_PSEL_RST);
		rchk(`SPR_A_MASK, `SPR_MASK_RST);
		rchk(`SPR_A_ROUTE, `SPR_ROUTE_RST);
		rchk(8'h14, 32'h0);
		chk(r, `SPR_RESP_ERR);
		wr(8'h14, 32'hffffffff);
		chk(r, `SPR_RESP_ERR);
		wr(`SPR_A_MASK, 32'hffff0005);
		rchk(`SPR_A_MASK, 32'h5);
		$display("TB: reset test done");
	endtask
	task t_unmux;
		repeat (4) @(negedge clk);
		chk(baud_clock_out, 3'b101);
		chk({pin_oen[0], pin_o[0]}, 2'b01);
		chk(pin_oen[7], 1'b1);
		chk(alt_i, pins_hi);
		wr(`SPR_A_PINSEL, 32'h1);
		@(negedge clk);
		chk({pin_oen[7], pin_o[7]}, 2'b01);
		$display("TB: unmuxed test done");
	endtask
	task t_link;
		@(posedge clk);
		scc_txd <= 3'b000;
		wr(`SPR_A_ROUTE, 32'h33);
		wr(`SPR_A_CFG, 32'h11);
		@(negedge clk);
		chk(baud_clock_out, 3'b100);
		chk(pin_o[1], 1'b1);
		frame(20'hfffff, 20'hfffff);
		chk(seen, 20'h7fdfa);
		chk(drv, 4);
		chk(nst, 2);
		chk(nrc, 2);
		chk(rx_or, 1'b1);
		chk(nmg, 2);
		chk(mgmt_rxd, 2'b11);
		wr(`SPR_A_CFG, 32'h211);
		frame(20'hfffff, 20'hfffff);
		chk(rx_or, 1'b0);
		chk(nrc, 2);
		wr(`SPR_A_CFG, 32'h111);
		frame(20'h5a3c6, 20'hfffff);
		chk(seen, 20'h5a3c6);
		chk(drv, 20);
		@(posedge clk);
		scc_dreq <= 3'b001;
		wr(`SPR_A_ROUTE, 32'h30);
		wr(`SPR_A_CFG, 32'h11);
		@(negedge clk);
		chk({pin_oen[4], pin_o[4]}, 2'b01);
		frame(20'hfffff, 20'hfffff);
		chk(seen, 20'h3fcfa);
		chk(drv, 6);
		chk(nrc, 4);
		chk(ntc, 4);
		chk(ndc, 0);
		frame(20'hfffff, 20'hffeff);
		chk(seen, 20'h7fdfa);
		chk(ndc, 1);
		@(posedge clk);
		scc_dreq <= 3'b000;
		@(negedge clk);
		chk(pin_o[4], 1'b0);
		$display("TB: link test done");
	endtask
	task t_combos;
		scc_brg <= 3'b111;
		wr(`SPR_A_CFG, 32'h2);
		rd(`SPR_A_STATUS);
		chk(d[8], 1'b1);
		chk(baud_clock_out, 3'b111);
		for (int b = 0; b < 3; b++) begin
			wr(`SPR_A_CFG, 32'h3 | (b << 4));
			rchk(`SPR_A_CFG, 32'h3 | (b << 4));
		end
		rd(`SPR_A_STATUS);
		chk(d[8], 1'b0);
		chk(baud_clock_out, 3'b100);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rchk(`SPR_A_CFG, `SPR_CFG_RST);
		chk(baud_clock_out, 3'b111);
		$display("TB: combination test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
		{scc_txd, scc_rts, scc_brg, scc_dreq, mgmt_txd} = {3'b011, 3'b000, 3'b101, 3'b000, 2'b00};
		{alt_o, alt_oen, pins_hi} = {14'h0000, 14'h0001, 14'h1a5c};
		{num_errors, check_count, cyc} = {32'd0, 32'd0, 32'd0};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_unmux;
		t_link;
		t_combos;
		tally_and_finish;
	end
endmodule
bind spr_router spr_router_monitor mon_u (.clk, .rstn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .scc_brg, .baud_clock_out, .mgmt_tstb,
	.first_bearer_strobe, .second_bearer_strobe);
`default_nettype wire
